// ===== hw/fp_operand_pkg.sv
// Purpose: Shared constants for the floating operand and result unit
// Assumes: 10 MHz clock, plain register port with one-cycle read latency
// Notes: Byte offsets are word aligned; unmapped reads return zero
package fp_operand_pkg;
    // ****************************************
    // Register port
    // ****************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_INSTR = 8'h08;
    localparam logic [7:0] OFF_RES_HI = 8'h0c;
    localparam logic [7:0] OFF_RES_LO = 8'h10;
    // Control register bit positions
    localparam int CTL_DBL = 0;
    localparam int CTL_LONG = 1;
    localparam int CTL_TRUNC = 2;
    localparam int CTL_IUV = 3;
    localparam int CTL_IV = 4;
    localparam int CTL_IU = 5;
    localparam int CTL_W = 6;
    localparam logic [5:0] CTRL_RST = 6'h00;
    // Instruction register extra marker bits
    localparam int INS_INT = 16;
    localparam int INS_SGL = 17;
    // Status register field positions
    localparam int STAT_EXC_LSB = 8;
    // ****************************************
    // Instruction format
    // ****************************************
    localparam logic [3:0] MAJOR_OP = 4'hf;
    localparam logic [2:0] MODE_ACC = 3'h0;
    localparam logic [2:0] MODE_DEF = 3'h1;
    localparam logic [2:0] MODE_AINC = 3'h2;
    localparam logic [2:0] MODE_AINC_D = 3'h3;
    localparam logic [2:0] MODE_ADEC = 3'h4;
    localparam logic [2:0] MODE_ADEC_D = 3'h5;
    localparam logic [2:0] MODE_IDX = 3'h6;
    localparam logic [2:0] MODE_IDX_D = 3'h7;
    localparam logic [2:0] ACC_LAST = 3'h5;
    localparam logic [4:0] STEP_SGL = 5'h04;
    localparam logic [4:0] STEP_DBL = 5'h08;
    // ****************************************
    // Exception cause codes
    // ****************************************
    localparam logic [3:0] EXC_NONE = 4'h0;
    localparam logic [3:0] EXC_OPCODE = 4'h2;
    localparam logic [3:0] EXC_DIVZ = 4'h4;
    localparam logic [3:0] EXC_OVF = 4'h8;
    localparam logic [3:0] EXC_UNF = 4'ha;
    localparam logic [3:0] EXC_UNDEF = 4'hc;
    // ****************************************
    // Number format
    // ****************************************
    localparam int EXP_W = 8;
    localparam int FRAC_W = 56;
    localparam int SGL_FRAC_W = 24;
    localparam int GUARD_W = 2;
    localparam int RAW_W = FRAC_W + GUARD_W;
    localparam logic signed [9:0] EXP_MAX = 10'sh0ff;
    localparam logic signed [9:0] EXP_MIN = 10'sh001;
endpackage : fp_operand_pkg

// ===== hw/fp_operand_unit.sv
// Purpose: Floating operand addressing decode and result handling
// Assumes: Core issues one of abs, result, zero check or instruction per cycle
// Notes: Value layout is sign 63, biased exponent 62:55, fraction 54:0
//
// Functional notes
// [RL1] Mode 0 addresses the selected floating accumulator, not a general register.
// [RL2] Modes 1..7: deferred, autoinc, autoinc-def, autodec, autodec-def, indexed, idx-def.
// [RL3] Auto step is 4 for single precision and 8 for double precision.
// [RL4] Mode 0 accepts accumulators 0..5; naming 6 or 7 traps as illegal op code.
// [RL5] Memory and register modes use only accumulators 0..3, a 2-bit field.
// [RL6] Lowest memory address holds the most significant word.
// [RL7] Exponent 0 is exact zero; minus zero traps when undefined-variable enabled.
// [RL8] Zero dividend is exact; zero divisor raises the divide interrupt.
// [RL9] Fractions are 24 bits single and 56 bits double, normalized.
// [RL10] Two guard bits kept beyond the fraction for chop and round.
// [RL11] Rounding adds one LSB when the first dropped bit is set.
// [RL12] Exponent is 8 bits; out of range results flag overflow or underflow.
// [RL13] Underflow with its interrupt disabled gives a zero result.
// [RL14] Enabled overflow or underflow stores fraction and low exponent bits, traps.
// [RL15] Stored exponent is 256 low on overflow, 256 high on nonzero underflow.
// [RL16] Precision bit picks single or double; long bit picks 32 or 16 bits.
// [RL17] Major code 17 octal in 15:12; fop, accumulator, operand field layout.
// [RL18] Float operands use float modes; integer operands use ordinary modes.
// [RL19] Absolute value clears sign, forces zero on zero exponent, sets flags.
// [RL20] Absolute value traps before execution on minus zero; no over/underflow. Code traps only with CTL_IUV set, else gives zero.
// [RL21] Chop bit set truncates results; clear rounds them.
// [RL22] Exception code 8 on overflow and 10 on underflow when enabled.
// [RL23] Operand specifier: mode in bits 5:3, register number in bits 2:0.
`timescale 1ns/1ps
module fp_operand_unit (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [fp_operand_pkg::ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_res_valid,
    input wire logic i_res_sign,
    input wire logic signed [9:0] i_res_exp,
    input wire logic [fp_operand_pkg::RAW_W-1:0] i_res_frac,
    input wire logic i_abs_valid,
    input wire logic [63:0] i_abs_opnd,
    input wire logic i_chk_valid,
    input wire logic i_chk_divisor,
    input wire logic [15:0] i_chk_word,
    input wire logic [1:0] i_word_sel,
    output logic [15:0] o_mem_word,
    output logic [63:0] o_result,
    output logic o_result_carry_flag,
    output logic o_result_overflow_flag,
    output logic o_result_zero_flag,
    output logic o_result_negative_flag,
    output logic o_trap,
    output logic [3:0] o_exception_cause_code,
    output logic o_opnd_zero,
    output logic o_instr_valid,
    output logic [5:0] o_float_operation_code,
    output logic [1:0] o_accumulator_select,
    output logic o_opnd_in_acc,
    output logic [2:0] o_opnd_num,
    output logic [2:0] o_mode,
    output logic o_deferred,
    output logic o_autoinc,
    output logic o_autodec,
    output logic o_indexed,
    output logic [4:0] o_reg_step,
    output logic o_double_precision_select,
    output logic o_long_integer_select
);
    import fp_operand_pkg::*;

    // ****************************************
    // State
    // ****************************************
    logic [CTL_W-1:0] ctrl_r, ctrl_nxt;
    logic [17:0] instr_r, instr_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [63:0] res_r, res_nxt;
    logic [15:0] word_r, word_nxt;
    logic fc_r, fc_nxt, fv_r, fv_nxt, fz_r, fz_nxt, fn_r, fn_nxt;
    logic trap_r, trap_nxt, zero_r, zero_nxt;
    logic [3:0] exc_r, exc_nxt;
    logic dv_r, dv_nxt, inacc_r, inacc_nxt, def_r, def_nxt;
    logic ainc_r, ainc_nxt, adec_r, adec_nxt, idx_r, idx_nxt;
    logic [5:0] fop_r, fop_nxt;
    logic [1:0] acc_r, acc_nxt;
    logic [2:0] num_r, num_nxt, mode_r, mode_nxt;
    logic [4:0] step_r, step_nxt;

    // ****************************************
    // Result rounding and range
    // ****************************************
    logic dbl, trunc;
    logic rb_s, rb_d;
    logic [SGL_FRAC_W:0] kept_s;
    logic [FRAC_W:0] kept_d;
    logic carry;
    logic [FRAC_W-2:0] frac_st;
    logic signed [9:0] exp_adj;
    logic res_ovf, res_unf;
    logic [63:0] res_packed;

    assign dbl = ctrl_r[CTL_DBL];
    assign trunc = ctrl_r[CTL_TRUNC];
    // First dropped bit; guard bits sit below the kept field, see [RL10] [RL9]
    assign rb_s = i_res_frac[RAW_W-SGL_FRAC_W-1] & ~trunc;   // see [RL21]
    assign rb_d = i_res_frac[GUARD_W-1] & ~trunc;
    // Add one LSB on a set rounding bit, see [RL11]
    assign kept_s = {1'b0, i_res_frac[RAW_W-1 -: SGL_FRAC_W]} + {{SGL_FRAC_W{1'b0}}, rb_s};
    assign kept_d = {1'b0, i_res_frac[RAW_W-1 -: FRAC_W]} + {{FRAC_W{1'b0}}, rb_d};
    assign carry = dbl ? kept_d[FRAC_W] : kept_s[SGL_FRAC_W];
    // Carry out renormalizes to 1.000, so stored fraction bits go to zero
    always_comb begin
        frac_st = '0;
        if (carry) begin
            frac_st = '0;
        end else if (dbl) begin
            frac_st = kept_d[FRAC_W-2:0];
        end else begin
            frac_st[FRAC_W-2 -: SGL_FRAC_W-1] = kept_s[SGL_FRAC_W-2:0];
        end
    end
    assign exp_adj = i_res_exp + {9'h000, carry};
    assign res_ovf = exp_adj > EXP_MAX;   // see [RL12]
    assign res_unf = exp_adj < EXP_MIN;
    // Low eight exponent bits give the 256 offset on wrap, see [RL15]
    assign res_packed = {i_res_sign, exp_adj[EXP_W-1:0], frac_st};

    // ****************************************
    // Instruction decode
    // ****************************************
    logic [17:0] iw;
    logic [2:0] d_mode, d_num;
    logic d_int, d_sgl, d_float_acc;

    assign iw = i_wdata[17:0];
    assign d_mode = iw[5:3];   // see [RL23]
    assign d_num = iw[2:0];
    assign d_int = iw[INS_INT];
    assign d_sgl = iw[INS_SGL];
    // Integer operands keep ordinary CPU modes, see [RL18]
    assign d_float_acc = (d_mode == MODE_ACC) && !d_int;   // see [RL1]

    // ****************************************
    // Next state
    // ****************************************
    logic wr_instr;
    logic [15:0] abs_hi;
    logic abs_neg0, chk_neg0, chk_zero;

    assign wr_instr = i_wr && (i_addr == OFF_INSTR);
    assign abs_hi = i_abs_opnd[63:48];
    assign abs_neg0 = abs_hi[15] && (abs_hi[14:7] == '0) && ctrl_r[CTL_IUV];   // see [RL20]
    assign chk_zero = i_chk_word[14:7] == '0;
    assign chk_neg0 = chk_zero && i_chk_word[15] && ctrl_r[CTL_IUV];

    always_comb begin
        ctrl_nxt = ctrl_r;
        instr_nxt = instr_r;
        res_nxt = res_r;
        fc_nxt = fc_r;
        fv_nxt = fv_r;
        fz_nxt = fz_r;
        fn_nxt = fn_r;
        trap_nxt = 1'b0;
        exc_nxt = exc_r;
        zero_nxt = zero_r;
        dv_nxt = dv_r;
        inacc_nxt = inacc_r;
        def_nxt = def_r;
        ainc_nxt = ainc_r;
        adec_nxt = adec_r;
        idx_nxt = idx_r;
        fop_nxt = fop_r;
        acc_nxt = acc_r;
        num_nxt = num_r;
        mode_nxt = mode_r;
        step_nxt = step_r;
        if (i_wr && (i_addr == OFF_CTRL)) begin
            ctrl_nxt = i_wdata[CTL_W-1:0];   // see [RL16]
        end
        if (i_abs_valid) begin
            if (abs_neg0) begin
                trap_nxt = 1'b1;   // see [RL20]
                exc_nxt = EXC_UNDEF;
            end else begin
                // Never raises overflow or underflow, see [RL19]
                res_nxt = (abs_hi[14:7] == '0) ? 64'h0 : {1'b0, i_abs_opnd[62:0]};
                fc_nxt = 1'b0;
                fv_nxt = 1'b0;
                fn_nxt = 1'b0;
                fz_nxt = abs_hi[14:7] == '0;
            end
        end else if (i_res_valid) begin
            fc_nxt = 1'b0;
            fv_nxt = res_ovf;
            if (res_ovf && ctrl_r[CTL_IV]) begin
                res_nxt = res_packed;   // see [RL14]
                trap_nxt = 1'b1;
                exc_nxt = EXC_OVF;   // see [RL22]
            end else if (res_unf && ctrl_r[CTL_IU]) begin
                res_nxt = res_packed;   // see [RL14] [RL15]
                trap_nxt = 1'b1;
                exc_nxt = EXC_UNF;   // see [RL22]
            end else if (res_ovf || res_unf) begin
                res_nxt = 64'h0;   // see [RL13]
            end else begin
                res_nxt = dbl ? res_packed : {res_packed[63:32], 32'h0};   // see [RL9]
            end
            fz_nxt = !(res_ovf || res_unf) ? 1'b0
                     : !(ctrl_r[CTL_IV] && res_ovf) && !(ctrl_r[CTL_IU] && res_unf);
            fn_nxt = i_res_sign && !fz_nxt;
        end else if (i_chk_valid) begin
            zero_nxt = chk_zero;   // see [RL7]
            if (chk_neg0) begin
                trap_nxt = 1'b1;   // see [RL7]
                exc_nxt = EXC_UNDEF;
            end else if (chk_zero && i_chk_divisor) begin
                trap_nxt = 1'b1;   // see [RL8]
                exc_nxt = EXC_DIVZ;
            end
        end else if (wr_instr) begin
            instr_nxt = iw;
            dv_nxt = iw[15:12] == MAJOR_OP;   // see [RL17]
            fop_nxt = d_sgl ? iw[11:6] : {2'b00, iw[11:8]};
            acc_nxt = d_sgl ? 2'b00 : iw[7:6];   // see [RL5]
            mode_nxt = d_mode;
            num_nxt = d_num;
            inacc_nxt = d_float_acc;
            def_nxt = (d_mode == MODE_DEF) || (d_mode == MODE_AINC_D)
                      || (d_mode == MODE_ADEC_D) || (d_mode == MODE_IDX_D);   // see [RL2]
            ainc_nxt = (d_mode == MODE_AINC) || (d_mode == MODE_AINC_D);
            adec_nxt = (d_mode == MODE_ADEC) || (d_mode == MODE_ADEC_D);
            idx_nxt = (d_mode == MODE_IDX) || (d_mode == MODE_IDX_D);
            step_nxt = (d_int || !dbl) ? STEP_SGL : STEP_DBL;   // see [RL3]
            if ((iw[15:12] == MAJOR_OP) && d_float_acc && (d_num > ACC_LAST)) begin
                trap_nxt = 1'b1;   // see [RL4]
                exc_nxt = EXC_OPCODE;
            end
        end
    end

    // Most significant word at the lowest address, see [RL6]
    always_comb begin
        case (i_word_sel)
            2'h0: word_nxt = res_r[63:48];
            2'h1: word_nxt = res_r[47:32];
            2'h2: word_nxt = res_r[31:16];
            default: word_nxt = res_r[15:0];
        endcase
    end

    always_comb begin
        rdata_nxt = 32'h0;
        if (i_rd) begin
            case (i_addr)
                OFF_CTRL: rdata_nxt = {26'h0, ctrl_r};
                OFF_STAT: rdata_nxt = {20'h0, exc_r, 4'h0, fn_r, fz_r, fv_r, fc_r};
                OFF_INSTR: rdata_nxt = {14'h0, instr_r};
                OFF_RES_HI: rdata_nxt = res_r[63:32];
                OFF_RES_LO: rdata_nxt = res_r[31:0];
                default: rdata_nxt = 32'h0;
            endcase
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_r <= CTRL_RST;
            instr_r <= '0;
            rdata_r <= '0;
            res_r <= '0;
            word_r <= '0;
            fc_r <= 1'b0;
            fv_r <= 1'b0;
            fz_r <= 1'b0;
            fn_r <= 1'b0;
            trap_r <= 1'b0;
            exc_r <= EXC_NONE;
            zero_r <= 1'b0;
            dv_r <= 1'b0;
            inacc_r <= 1'b0;
            def_r <= 1'b0;
            ainc_r <= 1'b0;
            adec_r <= 1'b0;
            idx_r <= 1'b0;
            fop_r <= '0;
            acc_r <= '0;
            num_r <= '0;
            mode_r <= '0;
            step_r <= STEP_SGL;
        end else begin
            ctrl_r <= ctrl_nxt;
            instr_r <= instr_nxt;
            rdata_r <= rdata_nxt;
            res_r <= res_nxt;
            word_r <= word_nxt;
            fc_r <= fc_nxt;
            fv_r <= fv_nxt;
            fz_r <= fz_nxt;
            fn_r <= fn_nxt;
            trap_r <= trap_nxt;
            exc_r <= exc_nxt;
            zero_r <= zero_nxt;
            dv_r <= dv_nxt;
            inacc_r <= inacc_nxt;
            def_r <= def_nxt;
            ainc_r <= ainc_nxt;
            adec_r <= adec_nxt;
            idx_r <= idx_nxt;
            fop_r <= fop_nxt;
            acc_r <= acc_nxt;
            num_r <= num_nxt;
            mode_r <= mode_nxt;
            step_r <= step_nxt;
        end
    end

    assign o_rdata = rdata_r;
    assign o_mem_word = word_r;
    assign o_result = res_r;
    assign o_result_carry_flag = fc_r;
    assign o_result_overflow_flag = fv_r;
    assign o_result_zero_flag = fz_r;
    assign o_result_negative_flag = fn_r;
    assign o_trap = trap_r;
    assign o_exception_cause_code = exc_r;
    assign o_opnd_zero = zero_r;
    assign o_instr_valid = dv_r;
    assign o_float_operation_code = fop_r;
    assign o_accumulator_select = acc_r;
    assign o_opnd_in_acc = inacc_r;
    assign o_opnd_num = num_r;
    assign o_mode = mode_r;
    assign o_deferred = def_r;
    assign o_autoinc = ainc_r;
    assign o_autodec = adec_r;
    assign o_indexed = idx_r;
    assign o_reg_step = step_r;
    assign o_double_precision_select = ctrl_r[CTL_DBL];
    assign o_long_integer_select = ctrl_r[CTL_LONG];   // see [RL16]

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_acc_trap_code: assert property (   // see [RL4]
        !i_abs_valid && !i_res_valid && !i_chk_valid && wr_instr
        && iw[15:12] == MAJOR_OP && d_float_acc && d_num > ACC_LAST
        |=> o_trap && o_exception_cause_code == EXC_OPCODE)
        else $error("illegal accumulator did not trap");
    a_step_size_sel: assert property (   // see [RL3]
        !i_abs_valid && !i_res_valid && !i_chk_valid && wr_instr && !d_int
        |=> o_reg_step == ($past(dbl) ? STEP_DBL : STEP_SGL))
        else $error("wrong register step");
    a_abs_clear_sign: assert property (   // see [RL19]
        i_abs_valid && !abs_neg0 |=> !o_result[63] && !o_result_negative_flag
        && !o_result_overflow_flag && !o_result_carry_flag
        && o_result_zero_flag == (o_result == 64'h0))
        else $error("absolute value result wrong");
    a_abs_neg0_trap: assert property (   // see [RL20]
        i_abs_valid && abs_neg0 |=> o_trap && o_exception_cause_code == EXC_UNDEF
        && $stable(o_result))
        else $error("minus zero absolute did not trap");
    a_divzero_trap: assert property (   // see [RL8]
        !i_abs_valid && !i_res_valid && i_chk_valid && chk_zero && i_chk_divisor
        && !chk_neg0 |=> o_trap && o_exception_cause_code == EXC_DIVZ)
        else $error("zero divisor did not trap");
    a_ovf_code_trap: assert property (   // see [RL22]
        !i_abs_valid && i_res_valid && res_ovf && ctrl_r[CTL_IV]
        |=> o_trap && o_exception_cause_code == EXC_OVF && o_result_overflow_flag)
        else $error("overflow code wrong");
    a_unf_zero_result: assert property (   // see [RL13]
        !i_abs_valid && i_res_valid && res_unf && !ctrl_r[CTL_IU]
        |=> o_result == 64'h0 && !o_trap)
        else $error("disabled underflow not zeroed");
    a_chop_keeps_bits: assert property (   // see [RL21]
        !i_abs_valid && i_res_valid && trunc && dbl && !res_ovf && !res_unf
        |=> o_result[54:0] == $past(i_res_frac[56:2]))
        else $error("chop altered fraction");
    a_word_order_msw: assert property (   // see [RL6]
        i_word_sel == 2'h0 |=> o_mem_word == $past(o_result[63:48]))
        else $error("word order wrong");

    c_round_carry: cover property (i_res_valid && carry && !trunc);
    c_unf_trap: cover property (i_res_valid && res_unf && ctrl_r[CTL_IU]);
    c_abs_zero: cover property (i_abs_valid && abs_hi[14:7] == '0 && !abs_neg0);
endmodule : fp_operand_unit

// ===== tb/fp_core_model.sv
// Purpose: Core-side model that offers results, abs operands and zero checks
// Assumes: Requests launch just after a rising edge and last one cycle
// Notes: Released data lines flip to the inverse of their last value
`timescale 1ns/1ps
module fp_core_model (
    input wire logic i_clk,
    output logic o_res_valid,
    output logic o_res_sign,
    output logic signed [9:0] o_res_exp,
    output logic [57:0] o_res_frac,
    output logic o_abs_valid,
    output logic [63:0] o_abs_opnd,
    output logic o_chk_valid,
    output logic o_chk_divisor,
    output logic [15:0] o_chk_word
);
    initial begin
        {o_res_valid, o_res_sign, o_res_exp, o_res_frac} = '0;
        {o_abs_valid, o_abs_opnd, o_chk_valid, o_chk_divisor, o_chk_word} = '0;
    end
    // ****************************************
    // Request tasks
    // ****************************************
    task automatic send_res(input logic s, input logic signed [9:0] e, input logic [57:0] f);
        @(posedge i_clk);
        {o_res_valid, o_res_sign, o_res_exp, o_res_frac} <= {1'b1, s, e, f};
        @(posedge i_clk);
        {o_res_valid, o_res_sign, o_res_exp, o_res_frac} <= {1'b0, ~s, ~e, ~f};
        #1;
    endtask : send_res
    task automatic send_abs(input logic [63:0] v);
        @(posedge i_clk);
        {o_abs_valid, o_abs_opnd} <= {1'b1, v};
        @(posedge i_clk);
        {o_abs_valid, o_abs_opnd} <= {1'b0, ~v};
        #1;
    endtask : send_abs
    task automatic send_chk(input logic d, input logic [15:0] w);
        @(posedge i_clk);
        {o_chk_valid, o_chk_divisor, o_chk_word} <= {1'b1, d, w};
        @(posedge i_clk);
        {o_chk_valid, o_chk_divisor, o_chk_word} <= {1'b0, ~d, ~w};
        #1;
    endtask : send_chk
endmodule : fp_core_model

// ===== tb/fp_operand_unit_tb.sv
// Purpose: Self-checking bench for the floating operand and result unit
// Assumes: One 10 MHz clock, reset held for four cycles
// Notes: Expected values are built from the number layout by hand
`timescale 1ns/1ps
module fp_operand_unit_tb;
    import fp_operand_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [1:0] wsel = 2'h0;
    logic [31:0] rdata, rv;
    logic rs_v, rs_s, ab_v, ck_v, ck_d;
    logic signed [9:0] rs_e;
    logic [57:0] rs_f;
    logic [63:0] ab_o, res, ex;
    logic [15:0] ck_w, mw;
    logic fc, fv, fz, fn, trap, ozero, ivld, inacc, dfr, ainc, adec, idx, dbl, lng;
    logic [3:0] code;
    logic [5:0] fop;
    logic [1:0] acc;
    logic [2:0] num, mode;
    logic [4:0] step;
    int bad_count = 0;
    int tests_run = 0;
    always #50 i_clk = ~i_clk;
    fp_operand_unit fp_operand_unit_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_res_valid(rs_v),
        .i_res_sign(rs_s), .i_res_exp(rs_e), .i_res_frac(rs_f), .i_abs_valid(ab_v),
        .i_abs_opnd(ab_o), .i_chk_valid(ck_v), .i_chk_divisor(ck_d), .i_chk_word(ck_w),
        .i_word_sel(wsel), .o_mem_word(mw), .o_result(res), .o_result_carry_flag(fc),
        .o_result_overflow_flag(fv), .o_result_zero_flag(fz), .o_result_negative_flag(fn),
        .o_trap(trap), .o_exception_cause_code(code), .o_opnd_zero(ozero),
        .o_instr_valid(ivld), .o_float_operation_code(fop), .o_accumulator_select(acc),
        .o_opnd_in_acc(inacc), .o_opnd_num(num), .o_mode(mode), .o_deferred(dfr),
        .o_autoinc(ainc), .o_autodec(adec), .o_indexed(idx), .o_reg_step(step),
        .o_double_precision_select(dbl), .o_long_integer_select(lng));
    fp_core_model fp_core_model_i (.i_clk(i_clk), .o_res_valid(rs_v), .o_res_sign(rs_s),
        .o_res_exp(rs_e), .o_res_frac(rs_f), .o_abs_valid(ab_v), .o_abs_opnd(ab_o),
        .o_chk_valid(ck_v), .o_chk_divisor(ck_d), .o_chk_word(ck_w));
    // ****************************************
    // Access and compare tasks
    // ****************************************
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge i_clk);
        wr <= 1'b0;
        #1;
    endtask : bus_wr
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk);
        {addr, rd} <= {a, 1'b1};
        @(posedge i_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : bus_rd
    task automatic rchk(input logic [63:0] r, input logic [4:0] tc, input logic [2:0] vzn);
        chk("result", r, res);
        chk("trap_code", {59'h0, tc}, {59'h0, trap, code});
        chk("flags", {60'h0, 1'b0, vzn}, {60'h0, fc, fv, fz, fn});
    endtask : rchk
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (3000) @(posedge i_clk);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        #1;
        chk("step_rst", 5'h4, step);
        bus_rd(OFF_CTRL, rv);
        chk("ctrl_rst", 32'h0, rv);
        bus_wr(OFF_CTRL, 32'h3);
        chk("sel", 2'h3, {dbl, lng});
        for (int m = 0; m < 8; m++) begin
            bus_wr(OFF_INSTR, {16'h0, 4'hf, 4'h5, 2'h2, m[2:0], 3'h3});
            chk("decode", {m[2:0], m == 2 || m == 3, m == 4 || m == 5, m > 5, m[0], m == 0,
                5'h8}, {mode, ainc, adec, idx, dfr, inacc, step});
            chk("fields", {1'b1, 6'h05, 2'h2, 3'h3}, {ivld, fop, acc, num});
        end
        bus_wr(OFF_INSTR, {15'h0, 1'b1, 4'hf, 4'h5, 2'h2, 3'h2, 3'h1});
        chk("int_step", 5'h4, step);
        bus_wr(OFF_CTRL, 32'h0);
        bus_wr(OFF_INSTR, {14'h0, 2'h2, 4'hf, 6'h06, 3'h4, 3'h2});
        chk("single", {6'h06, 2'h0, 5'h4}, {fop, acc, step});
        bus_wr(OFF_INSTR, {16'h0, 4'hf, 4'h1, 2'h0, 3'h0, 3'h6});
        chk("acc6", 5'h12, {trap, code});
        bus_wr(OFF_INSTR, {16'h0, 4'hf, 4'h1, 2'h0, 3'h0, 3'h5});
        chk("acc5", 2'h1, {trap, inacc});
        bus_wr(OFF_INSTR, {16'h0, 4'he, 12'h0});
        chk("major", 1'b0, ivld);
        fp_core_model_i.send_res(1'b0, 10'sd100, {1'b1, 23'h0, 1'b1, 33'h0});
        rchk({1'b0, 8'd100, 23'h1, 32'h0}, 5'h02, 3'h0);
        bus_wr(OFF_CTRL, 32'h4);
        fp_core_model_i.send_res(1'b0, 10'sd100, {1'b1, 23'h0, 1'b1, 33'h0});
        rchk({1'b0, 8'd100, 23'h0, 32'h0}, 5'h02, 3'h0);
        bus_wr(OFF_CTRL, 32'h0);
        fp_core_model_i.send_res(1'b1, 10'sd100, {24'hffffff, 1'b1, 33'h0});
        rchk({1'b1, 8'd101, 55'h0}, 5'h02, 3'h1);
        bus_wr(OFF_CTRL, 32'h1);
        fp_core_model_i.send_res(1'b0, 10'sd100, {1'b1, 55'h0, 2'h2});
        rchk({1'b0, 8'd100, 55'h1}, 5'h02, 3'h0);
        bus_wr(OFF_CTRL, 32'h5);
        fp_core_model_i.send_res(1'b0, 10'sd100, {1'b1, 55'h0, 2'h2});
        rchk({1'b0, 8'd100, 55'h0}, 5'h02, 3'h0);
        bus_wr(OFF_CTRL, 32'h11);
        fp_core_model_i.send_res(1'b0, 10'sd300, {1'b1, 57'h0});
        rchk({1'b0, 8'd44, 55'h0}, 5'h18, 3'h4);
        bus_wr(OFF_CTRL, 32'h1);
        fp_core_model_i.send_res(1'b0, 10'sd300, {1'b1, 57'h0});
        rchk(64'h0, 5'h08, 3'h6);
        bus_wr(OFF_CTRL, 32'h21);
        fp_core_model_i.send_res(1'b0, -10'sd5, {1'b1, 57'h0});
        rchk({1'b0, 8'd251, 55'h0}, 5'h1a, 3'h0);
        bus_wr(OFF_CTRL, 32'h1);
        fp_core_model_i.send_res(1'b0, -10'sd5, {1'b1, 57'h0});
        rchk(64'h0, 5'h0a, 3'h2);
        bus_wr(OFF_CTRL, 32'h8);
        ex = {1'b0, 8'd5, 55'h3456789abcdef};
        fp_core_model_i.send_abs({1'b1, ex[62:0]});
        rchk(ex, 5'h0a, 3'h0);
        for (int w = 0; w < 4; w++) begin
            @(posedge i_clk);
            wsel <= w[1:0];
            @(posedge i_clk);
            #1;
            chk("mem_word", ex[63 - 16 * w -: 16], mw);
        end
        fp_core_model_i.send_abs({1'b1, 8'h0, 55'h7});
        rchk(ex, 5'h1c, 3'h0);
        bus_wr(OFF_CTRL, 32'h0);
        fp_core_model_i.send_abs({1'b1, 8'h0, 55'h7});
        rchk(64'h0, 5'h0c, 3'h2);
        fp_core_model_i.send_chk(1'b1, 16'h0000);
        chk("divz", 6'h34, {ozero, trap, code});
        fp_core_model_i.send_chk(1'b0, 16'h0400);
        chk("nonzero", 6'h04, {ozero, trap, code});
        fp_core_model_i.send_chk(1'b0, 16'h0000);
        chk("dividend", 6'h24, {ozero, trap, code});
        bus_wr(OFF_CTRL, 32'h8);
        fp_core_model_i.send_chk(1'b0, 16'h8000);
        chk("minus0", 6'h3c, {ozero, trap, code});
        bus_rd(OFF_STAT, rv);
        chk("stat_code", 4'hc, rv[11:8]);
        bus_rd(8'h40, rv);
        chk("unmapped", 32'h0, rv);
        tally_and_finish();
    end
endmodule : fp_operand_unit_tb
